// ### core/iod_addr_gen.sv
`timescale 1ns/1ps
`include "iod_defs.svh"
module iod_addr_gen #(
  parameter int AW = `IOD_ADDR_W
) (
  iod_addr_if.gen aif
);

  // ---------------------------------------------------------------
  // operand address selection
  // ---------------------------------------------------------------
  // banked access wins, then indexed, then the two access-bank halves
  always_comb begin
    aif.indexed = 1'b0;
    if (aif.access) begin
      aif.addr = {aif.bank, aif.offs}; // RULE10
    end else if (aif.ext && (aif.offs <= `IOD_IDX_LIMIT)) begin
      aif.indexed = 1'b1; // RULE1 RULE9
      aif.addr = AW'(aif.fsr + AW'(aif.offs)); // wraps at the top of data space
    end else if (aif.offs <= `IOD_IDX_LIMIT) begin
      aif.addr = {{(AW-8){1'b0}}, aif.offs}; // RULE10
    end else begin
      aif.addr = {{(AW-8){1'b1}}, aif.offs}; // RULE11
    end
  end

endmodule : iod_addr_gen

// ### core/iod_addr_if.sv
`timescale 1ns/1ps
`include "iod_defs.svh"
interface iod_addr_if #(
  parameter int AW = `IOD_ADDR_W
) ();
  logic ext;
  logic access;
  logic [7:0] offs;
  logic [AW-1:0] fsr;
  logic [AW-9:0] bank;
  logic [AW-1:0] addr;
  logic indexed;

  modport req (output ext, access, offs, fsr, bank, input addr, indexed);
  modport gen (input ext, access, offs, fsr, bank, output addr, indexed);
endinterface : iod_addr_if

// ### core/iod_defs.svh
// Behaviour
// RULE1 - extension on: access offsets up to 5Fh index
// RULE2 - indexed add: accumulator plus pointer-relative register
// RULE3 - destination bit 0 accumulator, 1 register
// RULE4 - indexed add updates N, OV, C, DC, Z
// RULE5 - add decodes from 0010 01d0 plus offset
// RULE6 - 1000 bbb0 sets bit b, flags untouched
// RULE7 - 0110 1000 writes FFh, flags untouched
// RULE8 - one word, one four-phase instruction cycle
// RULE9 - config bit 0 keeps indexed mode off
// RULE10 - extension off: access bit picks bank
// RULE11 - offsets above 5Fh stay literal access bank
`ifndef IOD_DEFS_SVH
`define IOD_DEFS_SVH

// ---------------------------------------------------------------
// widths and timing
// ---------------------------------------------------------------
`define IOD_ADDR_W 12
`define IOD_MCLK_PERIOD_NS 4
`define IOD_PHASES 4

// ---------------------------------------------------------------
// addressing
// ---------------------------------------------------------------
`define IOD_IDX_LIMIT 8'h5F
`define IOD_ACCESS_BIT 8

// ---------------------------------------------------------------
// opcode fields
// ---------------------------------------------------------------
`define IOD_ENC_ADD 6'h09
`define IOD_ENC_BITSET 4'h8
`define IOD_ENC_ALLONES 7'h34
`define IOD_DEST_BIT 9
`define IOD_ALL_ONES 8'hFF

// ---------------------------------------------------------------
// status bit positions and reset values
// ---------------------------------------------------------------
`define IOD_ST_C 0
`define IOD_ST_DC 1
`define IOD_ST_Z 2
`define IOD_ST_OV 3
`define IOD_ST_N 4
`define IOD_ST_RESET 5'h00

`endif

// ### core/iod_indexed_exec.sv
`timescale 1ns/1ps
`include "iod_defs.svh"
module iod_indexed_exec #(
  parameter int ADDR_W = `IOD_ADDR_W
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // configuration
  input wire logic i_ext_set_cfg,
  // instruction and core state
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [ADDR_W-1:0] i_stack_frame_ptr,
  input wire logic [ADDR_W-9:0] i_bank_select,
  input wire logic [7:0] i_wreg,
  // data memory
  output logic o_mem_rd,
  output logic [ADDR_W-1:0] o_mem_addr,
  input wire logic [7:0] i_mem_rdata,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  // results to the core
  output logic o_wreg_we,
  output logic [7:0] o_wreg_wdata,
  output logic o_status_we,
  output logic [4:0] o_status,
  output logic [1:0] o_phase,
  output logic o_busy,
  output logic o_indexed
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  iod_pkg::iod_phase_e phase_reg;
  iod_pkg::iod_phase_e phase_next;
  iod_pkg::iod_op_e op_reg;
  iod_pkg::iod_op_e op_next;
  logic dest_reg;
  logic dest_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic idx_reg;
  logic idx_next;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [4:0] flags_reg;
  logic [4:0] flags_next;
  logic [8:0] sum;
  logic [4:0] nib;

  iod_addr_if #(.AW(ADDR_W)) aif ();

  // ---------------------------------------------------------------
  // opcode decode
  // ---------------------------------------------------------------
  // the access bit is not part of the match; it only steers the address
  function automatic iod_pkg::iod_op_e decode_op(input logic [15:0] w);
    if (w[15:10] == `IOD_ENC_ADD) begin
      return iod_pkg::IOD_OP_ADD; // RULE5
    end else if (w[15:12] == `IOD_ENC_BITSET) begin
      return iod_pkg::IOD_OP_BITSET; // RULE6
    end else if (w[15:9] == `IOD_ENC_ALLONES) begin
      return iod_pkg::IOD_OP_ALLONES; // RULE7
    end
    return iod_pkg::IOD_OP_NONE;
  endfunction : decode_op

  // operand address from the low byte of the word
  assign aif.ext = i_ext_set_cfg; // RULE9
  assign aif.access = i_instr[`IOD_ACCESS_BIT];
  assign aif.offs = i_instr[7:0];
  assign aif.fsr = i_stack_frame_ptr;
  assign aif.bank = i_bank_select;

  iod_addr_gen #(.AW(ADDR_W)) u_addr (
    .aif(aif.gen)
  );

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  // free running, so every instruction takes exactly four clocks
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      iod_pkg::IOD_Q1: phase_next = iod_pkg::IOD_Q2;
      iod_pkg::IOD_Q2: phase_next = iod_pkg::IOD_Q3;
      iod_pkg::IOD_Q3: phase_next = iod_pkg::IOD_Q4;
      iod_pkg::IOD_Q4: phase_next = iod_pkg::IOD_Q1; // RULE8
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      phase_reg <= iod_pkg::IOD_Q1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ---------------------------------------------------------------
  // decode capture in Q1
  // ---------------------------------------------------------------
  // a word offered outside Q1 is not taken
  always_comb begin
    op_next = op_reg;
    dest_next = dest_reg;
    bit_next = bit_reg;
    addr_next = addr_reg;
    idx_next = idx_reg;
    if (phase_reg == iod_pkg::IOD_Q1) begin
      op_next = i_instr_valid ? decode_op(i_instr) : iod_pkg::IOD_OP_NONE; // RULE8
      dest_next = i_instr[`IOD_DEST_BIT]; // RULE3
      bit_next = i_instr[11:9]; // RULE6
      addr_next = aif.addr; // RULE1
      idx_next = aif.indexed && i_instr_valid && (decode_op(i_instr) != iod_pkg::IOD_OP_NONE);
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      op_reg <= iod_pkg::IOD_OP_NONE;
      dest_reg <= 1'b0;
      bit_reg <= 3'h0;
      addr_reg <= '0;
      idx_reg <= 1'b0;
    end else begin
      op_reg <= op_next;
      dest_reg <= dest_next;
      bit_reg <= bit_next;
      addr_reg <= addr_next;
      idx_reg <= idx_next;
    end
  end

  // ---------------------------------------------------------------
  // process in Q3
  // ---------------------------------------------------------------
  // read data returns one clock after the Q2 strobe, so it is live in Q3
  assign sum = {1'b0, i_wreg} + {1'b0, i_mem_rdata}; // RULE2
  assign nib = {1'b0, i_wreg[3:0]} + {1'b0, i_mem_rdata[3:0]};

  always_comb begin
    result_next = result_reg;
    flags_next = flags_reg;
    if (phase_reg == iod_pkg::IOD_Q3) begin
      unique case (op_reg)
        iod_pkg::IOD_OP_ADD: begin
          result_next = sum[7:0]; // RULE2
          flags_next[`IOD_ST_C] = sum[8]; // RULE4
          flags_next[`IOD_ST_DC] = nib[4];
          flags_next[`IOD_ST_Z] = (sum[7:0] == 8'h00);
          flags_next[`IOD_ST_OV] = (i_wreg[7] == i_mem_rdata[7]) && (sum[7] != i_wreg[7]);
          flags_next[`IOD_ST_N] = sum[7];
        end
        iod_pkg::IOD_OP_BITSET: begin
          result_next = i_mem_rdata | (8'h01 << bit_reg); // RULE6
        end
        iod_pkg::IOD_OP_ALLONES: begin
          result_next = `IOD_ALL_ONES; // RULE7
        end
        iod_pkg::IOD_OP_NONE: begin
          result_next = result_reg;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      result_reg <= 8'h00;
      flags_reg <= `IOD_ST_RESET;
    end else begin
      result_reg <= result_next;
      flags_reg <= flags_next;
    end
  end

  // ---------------------------------------------------------------
  // strobes and outputs
  // ---------------------------------------------------------------
  // read in Q2, write in Q4; flags only ever leave on an add
  assign o_mem_rd = (phase_reg == iod_pkg::IOD_Q2) && (op_reg != iod_pkg::IOD_OP_NONE); // RULE8
  assign o_mem_wr = (phase_reg == iod_pkg::IOD_Q4) &&
                    ((op_reg == iod_pkg::IOD_OP_BITSET) || (op_reg == iod_pkg::IOD_OP_ALLONES) ||
                     ((op_reg == iod_pkg::IOD_OP_ADD) && dest_reg)); // RULE3
  assign o_wreg_we = (phase_reg == iod_pkg::IOD_Q4) && (op_reg == iod_pkg::IOD_OP_ADD) && !dest_reg; // RULE3
  assign o_status_we = (phase_reg == iod_pkg::IOD_Q4) && (op_reg == iod_pkg::IOD_OP_ADD); // RULE4
  assign o_mem_addr = addr_reg;
  assign o_mem_wdata = result_reg;
  assign o_wreg_wdata = result_reg;
  assign o_status = flags_reg;
  assign o_phase = phase_reg;
  assign o_busy = (op_reg != iod_pkg::IOD_OP_NONE);
  assign o_indexed = idx_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_IDX_ADDR: assert property ( // RULE1
    @(posedge i_mclk) disable iff (i_rst)
    (phase_reg == iod_pkg::IOD_Q1 && i_instr_valid && i_ext_set_cfg && !i_instr[8] &&
     i_instr[7:0] <= 8'h5F && decode_op(i_instr) != iod_pkg::IOD_OP_NONE)
    |=> (o_mem_addr == ADDR_W'($past(i_stack_frame_ptr) + ADDR_W'($past(i_instr[7:0])))) && o_indexed && o_mem_rd)
    else $error("indexed address not pointer plus offset");

  AST_ADD_SUM: assert property ( // RULE2
    @(posedge i_mclk) disable iff (i_rst)
    o_status_we |-> o_mem_wdata == 8'($past(i_wreg) + $past(i_mem_rdata)))
    else $error("add result wrong");

  AST_ADD_DEST: assert property ( // RULE3
    @(posedge i_mclk) disable iff (i_rst)
    o_status_we |-> (o_mem_wr == $past(i_instr[9], 3)) && (o_wreg_we == !$past(i_instr[9], 3)))
    else $error("add destination wrong");

  AST_FLAGS: assert property ( // RULE4
    @(posedge i_mclk) disable iff (i_rst)
    o_status_we |-> (o_status[`IOD_ST_Z] == (o_mem_wdata == 8'h00)) && (o_status[`IOD_ST_N] == o_mem_wdata[7]) &&
                    (o_status[`IOD_ST_C] == ((9'($past(i_wreg)) + 9'($past(i_mem_rdata))) > 9'h0FF)))
    else $error("add flags wrong");

  AST_ADD_DECODE: assert property ( // RULE5
    @(posedge i_mclk) disable iff (i_rst)
    (phase_reg == iod_pkg::IOD_Q1 && i_instr_valid && i_instr[15:10] == 6'h09) |-> ##3 o_status_we)
    else $error("add pattern not executed");

  AST_BITSET: assert property ( // RULE6
    @(posedge i_mclk) disable iff (i_rst)
    (phase_reg == iod_pkg::IOD_Q1 && i_instr_valid && i_instr[15:12] == 4'h8) |->
    ##3 o_mem_wr && !o_status_we && (o_mem_wdata == ($past(i_mem_rdata) | (8'h01 << $past(i_instr[11:9], 3)))))
    else $error("bit set wrong");

  AST_ALLONES: assert property ( // RULE7
    @(posedge i_mclk) disable iff (i_rst)
    (phase_reg == iod_pkg::IOD_Q1 && i_instr_valid && i_instr[15:9] == 7'h34) |->
    ##3 o_mem_wr && !o_status_we && o_mem_wdata == 8'hFF)
    else $error("set all ones wrong");

  AST_ONE_CYCLE: assert property ( // RULE8
    @(posedge i_mclk) disable iff (i_rst)
    (phase_reg == iod_pkg::IOD_Q1 && i_instr_valid && decode_op(i_instr) != iod_pkg::IOD_OP_NONE) |->
    ##1 o_mem_rd ##1 !o_mem_rd ##1 (o_mem_wr || o_wreg_we) ##1 !o_mem_wr && !o_wreg_we)
    else $error("instruction not one four-phase cycle");

  AST_EXT_OFF: assert property ( // RULE9
    @(posedge i_mclk) disable iff (i_rst)
    (phase_reg == iod_pkg::IOD_Q1 && !i_ext_set_cfg) |=> !o_indexed [*3])
    else $error("indexed mode while extension off");

  AST_BANKED: assert property ( // RULE10
    @(posedge i_mclk) disable iff (i_rst)
    (phase_reg == iod_pkg::IOD_Q1 && i_instr[8]) |=> o_mem_addr == {$past(i_bank_select), $past(i_instr[7:0])})
    else $error("banked address wrong");

  AST_HI_ACCESS: assert property ( // RULE11
    @(posedge i_mclk) disable iff (i_rst)
    (phase_reg == iod_pkg::IOD_Q1 && !i_instr[8] && i_instr[7:0] > 8'h5F) |=>
    o_mem_addr == {{(ADDR_W-8){1'b1}}, $past(i_instr[7:0])} && !o_indexed)
    else $error("upper access bank not literal");

endmodule : iod_indexed_exec

// ### core/iod_pkg.sv
package iod_pkg;

  // quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    IOD_Q1,
    IOD_Q2,
    IOD_Q3,
    IOD_Q4
  } iod_phase_e;

  // operations this block executes
  typedef enum logic [1:0] {
    IOD_OP_NONE,
    IOD_OP_ADD,
    IOD_OP_BITSET,
    IOD_OP_ALLONES
  } iod_op_e;

endpackage : iod_pkg

// ### tb/iod_indexed_exec_test.sv
`timescale 1ns/1ps
module iod_indexed_exec_test;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ext_set_cfg = 1'b0;
  logic i_instr_valid = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [11:0] i_stack_frame_ptr = 12'h000;
  logic [3:0] i_bank_select = 4'h0;
  logic [7:0] i_wreg = 8'h00;
  logic [7:0] i_mem_rdata = 8'h00;
  logic o_mem_rd, o_mem_wr, o_wreg_we, o_status_we, o_busy, o_indexed;
  logic [11:0] o_mem_addr;
  logic [7:0] o_mem_wdata, o_wreg_wdata;
  logic [4:0] o_status;
  logic [1:0] o_phase;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed;

  // 4 ns period
  always #2 i_mclk = ~i_mclk;

  iod_indexed_exec #(.ADDR_W(12)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ext_set_cfg(i_ext_set_cfg),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_stack_frame_ptr(i_stack_frame_ptr),
    .i_bank_select(i_bank_select), .i_wreg(i_wreg), .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
    .i_mem_rdata(i_mem_rdata), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_wreg_we(o_wreg_we),
    .o_wreg_wdata(o_wreg_wdata), .o_status_we(o_status_we), .o_status(o_status), .o_phase(o_phase),
    .o_busy(o_busy), .o_indexed(o_indexed));

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic int op_of(input logic [15:0] ins);
    if (ins[15:10] == 6'h09) return 1;
    if (ins[15:12] == 4'h8) return 2;
    if (ins[15:9] == 7'h34) return 3;
    return 0;
  endfunction : op_of

  function automatic logic [11:0] exp_addr(input logic ext, input logic [15:0] ins, input logic [11:0] fsr,
      input logic [3:0] bank);
    if (ins[8]) return {bank, ins[7:0]};
    if (ext && ins[7:0] <= 8'h5F) return fsr + {4'h0, ins[7:0]};
    return {(ins[7:0] <= 8'h5F) ? 4'h0 : 4'hF, ins[7:0]};
  endfunction : exp_addr

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // ------------------------------------------------------------
  // one instruction cycle, entered and left at a Q1 falling edge
  // ------------------------------------------------------------
  task automatic run_op(input logic ext, input logic v, input logic [15:0] ins, input logic [11:0] fsr,
      input logic [3:0] bank, input logic [7:0] w, input logic [7:0] r);
    int op;
    logic [8:0] s;
    logic [7:0] wd;
    logic [4:0] st;
    op = v ? op_of(ins) : 0;
    s = {1'b0, w} + {1'b0, r};
    wd = (op == 1) ? s[7:0] : (op == 2) ? (r | (8'h01 << ins[11:9])) : 8'hFF;
    st = {s[7], (w[7] == r[7]) && (s[7] != w[7]), s[7:0] == 8'h00,
      ({1'b0, w[3:0]} + {1'b0, r[3:0]}) > 5'h0F, s[8]};
    i_ext_set_cfg = ext;
    i_instr_valid = v;
    i_instr = ins;
    i_stack_frame_ptr = fsr;
    i_bank_select = bank;
    @(negedge i_mclk);
    chk(o_phase, 16'h1);
    chk(o_mem_rd, op != 0);
    chk(o_busy, op != 0);
    if (op != 0) begin
      chk(o_mem_addr, exp_addr(ext, ins, fsr, bank));
    end
    // unrecognised or refused words must never claim the indexed path
    chk(o_indexed, op != 0 && !ins[8] && ext && ins[7:0] <= 8'h5F);
    // a live set-all word outside Q1 must be ignored
    i_instr_valid = 1'b1;
    i_instr = 16'h68FF;
    i_mem_rdata = r;
    i_wreg = w;
    @(negedge i_mclk);
    @(negedge i_mclk);
    chk(o_phase, 16'h3);
    chk(o_mem_wr, op > 1 || (op == 1 && ins[9]));
    chk(o_wreg_we, op == 1 && !ins[9]);
    chk(o_status_we, op == 1);
    if (op > 1 || (op == 1 && ins[9])) chk(o_mem_wdata, wd);
    if (op == 1 && !ins[9]) chk(o_wreg_wdata, wd);
    if (op == 1) chk(o_status, st);
    // released bus: show the inverse, not the old value
    i_mem_rdata = ~r;
    @(negedge i_mclk);
  endtask : run_op

  // ------------------------------------------------------------
  // hang guard, well above the roughly 1140 cycles expected
  // ------------------------------------------------------------
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = $urandom(32'h44a622f5);
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    // worked add, both destinations, and flag corners
    run_op(1'b1, 1'b1, 16'h242C, 12'hA00, 4'h3, 8'h17, 8'h20);
    run_op(1'b1, 1'b1, 16'h262C, 12'hA00, 4'h3, 8'h17, 8'h20);
    run_op(1'b1, 1'b1, 16'h2400, 12'h100, 4'h3, 8'h80, 8'h80);
    run_op(1'b1, 1'b1, 16'h2601, 12'h100, 4'h3, 8'h0F, 8'h01);
    run_op(1'b1, 1'b1, 16'h245F, 12'h100, 4'h3, 8'h7F, 8'h01);
    $display("test add done");
    // every bit position, then set-all
    for (int b = 0; b < 8; b++) run_op(1'b1, 1'b1, {4'h8, 3'(b), 9'h00A}, 12'hA00, 4'h1, 8'h00, 8'h55);
    run_op(1'b1, 1'b1, 16'h682C, 12'hA00, 4'h1, 8'h00, 8'h00);
    $display("test bit set and set-all done");
    // offset boundary, wrap, both modes, both access settings
    for (int i = 0; i < 16; i++) begin
      run_op(i[0], 1'b1, {7'h13, i[1], (i[3:2] == 0) ? 8'h00 : (i[3:2] == 1) ? 8'h5F : (i[3:2] == 2) ? 8'h60 : 8'hFF},
        12'hFF0, 4'h5, 8'h11, 8'h22);
    end
    $display("test addressing done");
    // refused words: not valid, unknown opcodes
    run_op(1'b1, 1'b0, 16'h262C, 12'hA00, 4'h1, 8'h01, 8'h02);
    run_op(1'b1, 1'b1, 16'hF000, 12'hA00, 4'h1, 8'h01, 8'h02);
    run_op(1'b1, 1'b1, 16'h6A00, 12'hA00, 4'h1, 8'h01, 8'h02);
    $display("test refusal done");
    // reset in mid-instruction drops the pending write
    i_ext_set_cfg = 1'b1;
    i_instr_valid = 1'b1;
    i_instr = 16'h682C;
    @(negedge i_mclk);
    i_rst = 1'b1;
    @(negedge i_mclk);
    chk(o_mem_wr, 16'h0);
    chk(o_phase, 16'h0);
    chk(o_busy, 16'h0);
    i_rst = 1'b0;
    run_op(1'b1, 1'b1, 16'h682C, 12'h200, 4'h1, 8'h00, 8'h00);
    $display("test reset done");
    // random mix, junk opcodes among it
    for (int n = 0; n < 250; n++) begin
      logic [15:0] ins;
      ins = 16'($urandom);
      case ($urandom_range(0, 3))
        0: ins[15:12] = 4'hF;
        1: ins[15:10] = 6'h09;
        2: ins[15:12] = 4'h8;
        default: ins[15:9] = 7'h34;
      endcase
      run_op(1'($urandom), 1'b1, ins, 12'($urandom), 4'($urandom), 8'($urandom), 8'($urandom));
    end
    $display("test random done");
    i_instr_valid = 1'b0;
    end_of_test();
  end
endmodule : iod_indexed_exec_test
